// file: logic/pci_irq_agent.sv
// requesting agent: per-function pending requests driven onto shared open-drain lines
`timescale 1ns/1ns
module pci_irq_agent
    import pci_irq_pkg::*;
#(
    parameter int NUM_FN = 1,
    parameter int NUM_LINES = 1,
    // two bits per function: line index from its interrupt pin register
    parameter logic [2*MAX_FN-1:0] FN_PIN = '0
)(
    input wire logic aclk,
    input wire logic aresetn,
    pci_irq_if.agent link,
    input wire logic [NUM_FN-1:0] fn_event,
    input wire logic [NUM_FN-1:0] fn_clear,
    input wire logic sys_err,
    input wire logic serr_clear,
    output logic [NUM_FN-1:0] fn_pending,
    output logic serr_active
);
    typedef struct packed {
        logic [NUM_FN-1:0] pending;
        logic serr_drv;
        logic [NUM_INTX-1:0] intx_oe;
    } agent_s;

    agent_s st_ff;
    agent_s nxt_st;

    // line actually used by a function
    function automatic int line_of(input int fn);
        int pin;
        pin = int'(FN_PIN[2*fn +: 2]);
        if (NUM_FN == 1) begin
            return 0;
        end
        if (pin >= NUM_LINES) begin
            return 0;
        end
        return pin;
    endfunction

    always_comb begin
        nxt_st = st_ff;
        // held until the driver clears; a new event wins over the clear
        nxt_st.pending = (st_ff.pending & ~fn_clear) | fn_event;
        nxt_st.serr_drv = (st_ff.serr_drv && !serr_clear) || sys_err;
        nxt_st.intx_oe = '0;
        for (int f = 0; f < NUM_FN; f++) begin
            if (nxt_st.pending[f]) begin
                nxt_st.intx_oe[line_of(f)] = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // open drain: only ever pulls low
    assign link.intx_o = '0;
    assign link.intx_oe = st_ff.intx_oe;
    assign link.serr_o = 1'b0;
    assign link.serr_oe = st_ff.serr_drv;
    assign fn_pending = st_ff.pending;
    assign serr_active = st_ff.serr_drv;
endmodule

// file: logic/pci_irq_board.sv
// board interrupt logic: line routing, system error NMI path, AXI4-Lite registers
`timescale 1ns/1ns
module pci_irq_board
    import pci_irq_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    pci_irq_if.board link,
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic nmi,
    output logic [SEC_LINES-1:0] sec_irq,
    output logic irq
);
    typedef struct packed {
        logic [NUM_INTX-1:0] intx_meta;
        logic [NUM_INTX-1:0] intx_sync;
        logic serr_meta;
        logic serr_sync;
        logic [NUM_INTX-1:0] intx_prev;
        logic serr_stat;
        logic serr_dis;
        logic nmi_mask;
        logic [6:0] clk_index;
        logic [NUM_INTX*ROUTE_W-1:0] route;
        logic [EV_W-1:0] ev_stat;
        logic [EV_W-1:0] ev_mask;
        logic nmi;
        logic [SEC_LINES-1:0] sec_irq;
        logic irq;
        logic aw_got;
        logic [AXI_AW-1:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } board_s;

    board_s st_ff;
    board_s nxt_st;

    function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
        return (a == ADDR_SSC) || (a == ADDR_NMC) || (a == ADDR_ROUTE) ||
               (a == ADDR_EV_STAT) || (a == ADDR_EV_MASK);
    endfunction

    logic [NUM_INTX-1:0] intx_act;
    logic serr_act;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;
    logic [ROUTE_W-1:0] sel;

    always_comb begin
        nxt_st = st_ff;
        ev_clr = '0;
        sel = '0;
        // two-stage synchronisers; only the second stage is used
        nxt_st.intx_meta = link.intx_i;
        nxt_st.intx_sync = st_ff.intx_meta;
        nxt_st.serr_meta = link.serr_i;
        nxt_st.serr_sync = st_ff.serr_meta;
        intx_act = ~st_ff.intx_sync;
        serr_act = ~st_ff.serr_sync;

        // write channel capture, either order
        if (s_axi_awvalid && st_ff.awready) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_ff.wready) begin
            nxt_st.w_got = 1'b1;
            nxt_st.wdata = s_axi_wdata;
            nxt_st.wstrb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = is_mapped(st_ff.awaddr) ? RESP_OKAY : RESP_SLVERR;
            if (st_ff.wstrb[0]) begin
                case (st_ff.awaddr)
                    ADDR_SSC: begin
                        // status bit is read-only, written value ignored
                        nxt_st.serr_dis = st_ff.wdata[SSC_EN_BIT];
                    end
                    ADDR_NMC: begin
                        nxt_st.nmi_mask = st_ff.wdata[NMC_MASK_BIT];
                        nxt_st.clk_index = st_ff.wdata[6:0];
                    end
                    ADDR_ROUTE: begin
                        nxt_st.route[7:0] = st_ff.wdata[7:0];
                    end
                    ADDR_EV_STAT: begin
                        ev_clr = st_ff.wdata[EV_W-1:0];
                    end
                    ADDR_EV_MASK: begin
                        nxt_st.ev_mask = st_ff.wdata[EV_W-1:0];
                    end
                    default: begin
                    end
                endcase
            end
            if (st_ff.wstrb[1] && st_ff.awaddr == ADDR_ROUTE) begin
                nxt_st.route[NUM_INTX*ROUTE_W-1:8] = st_ff.wdata[NUM_INTX*ROUTE_W-1:8];
            end
        end
        nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
        nxt_st.wready = !nxt_st.w_got && !nxt_st.bvalid;

        // read channel
        if (s_axi_rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_ff.arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = '0;
            nxt_st.rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr)
                ADDR_SSC: begin
                    nxt_st.rdata[SSC_STAT_BIT] = st_ff.serr_stat;
                    nxt_st.rdata[SSC_EN_BIT] = st_ff.serr_dis;
                end
                ADDR_ROUTE: begin
                    nxt_st.rdata[NUM_INTX*ROUTE_W-1:0] = st_ff.route;
                end
                ADDR_EV_STAT: begin
                    nxt_st.rdata[EV_W-1:0] = st_ff.ev_stat;
                end
                ADDR_EV_MASK: begin
                    nxt_st.rdata[EV_W-1:0] = st_ff.ev_mask;
                end
                default: begin
                end
            endcase
        end
        nxt_st.arready = !nxt_st.rvalid;

        // system error flag: sticky until the clear/disable bit is set
        if (st_ff.serr_dis) begin
            nxt_st.serr_stat = 1'b0;
        end else if (serr_act) begin
            nxt_st.serr_stat = 1'b1;
        end
        nxt_st.nmi = nxt_st.serr_stat && !nxt_st.nmi_mask;

        // route each active line to its firmware-chosen secondary input
        nxt_st.sec_irq = '0;
        for (int i = 0; i < NUM_INTX; i++) begin
            sel = st_ff.route[i*ROUTE_W +: ROUTE_W];
            if (intx_act[i]) begin
                nxt_st.sec_irq[sel] = 1'b1;
            end
        end

        // sticky events, set wins over write-one-to-clear
        ev_set = '0;
        ev_set[EV_SERR] = nxt_st.serr_stat && !st_ff.serr_stat;
        ev_set[EV_INTX_LSB +: NUM_INTX] = intx_act & ~st_ff.intx_prev;
        nxt_st.intx_prev = intx_act;
        nxt_st.ev_stat = (st_ff.ev_stat & ~ev_clr) | ev_set;
        nxt_st.irq = |(nxt_st.ev_stat & nxt_st.ev_mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
            st_ff.intx_meta <= '1;
            st_ff.intx_sync <= '1;
            st_ff.intx_prev <= '0;
            st_ff.serr_meta <= 1'b1;
            st_ff.serr_sync <= 1'b1;
            st_ff.serr_dis <= SSC_EN_RST;
            st_ff.nmi_mask <= NMC_MASK_RST;
            st_ff.route <= ROUTE_RST;
            st_ff.ev_mask <= EV_MASK_RST;
            st_ff.awready <= 1'b1;
            st_ff.wready <= 1'b1;
            st_ff.arready <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready = st_ff.wready;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;
    assign s_axi_rvalid = st_ff.rvalid;
    assign nmi = st_ff.nmi;
    assign sec_irq = st_ff.sec_irq;
    assign irq = st_ff.irq;
endmodule

// file: logic/pci_irq_if.sv
// shared open-drain interrupt and system error wires between agents and board
`timescale 1ns/1ns
interface pci_irq_if import pci_irq_pkg::*; ();
    logic [NUM_INTX-1:0] intx_o;
    logic [NUM_INTX-1:0] intx_oe;
    logic [NUM_INTX-1:0] intx_i;
    logic serr_o;
    logic serr_oe;
    logic serr_i;
    // pulled-up wires, low while any driver pulls low
    assign intx_i = ~(intx_oe & ~intx_o);
    assign serr_i = ~(serr_oe & ~serr_o);
    modport agent(output intx_o, output intx_oe, output serr_o, output serr_oe,
                  input intx_i, input serr_i);
    modport board(input intx_i, input serr_i);
endinterface

// file: logic/pci_irq_pkg.sv
// constants and register map shared by both ends of the interrupt link
package pci_irq_pkg;
    localparam int NUM_INTX = 4;
    localparam int SEC_LINES = 8;
    localparam int ROUTE_W = 3;
    localparam int EV_W = 5;
    localparam int AXI_AW = 12;
    localparam int MAX_FN = 8;
    // printed port numbers are register indices; byte address is four times the index
    localparam logic [7:0] SSC_INDEX = 8'h61;
    localparam logic [7:0] NMC_INDEX = 8'h70;
    localparam logic [AXI_AW-1:0] ADDR_SSC = {2'h0, SSC_INDEX, 2'h0};
    localparam logic [AXI_AW-1:0] ADDR_NMC = {2'h0, NMC_INDEX, 2'h0};
    localparam logic [AXI_AW-1:0] ADDR_ROUTE = 12'h200;
    localparam logic [AXI_AW-1:0] ADDR_EV_STAT = 12'h204;
    localparam logic [AXI_AW-1:0] ADDR_EV_MASK = 12'h208;
    localparam int SSC_STAT_BIT = 7;
    localparam int SSC_EN_BIT = 2;
    localparam int NMC_MASK_BIT = 7;
    localparam int EV_SERR = 0;
    localparam int EV_INTX_LSB = 1;
    localparam logic SSC_EN_RST = 1'h0;
    localparam logic NMC_MASK_RST = 1'h0;
    localparam logic [NUM_INTX*ROUTE_W-1:0] ROUTE_RST = 12'h688;
    localparam logic [EV_W-1:0] EV_MASK_RST = 5'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: sim/pci_irq_properties.sv
// link and output properties of the board and agent pair
`timescale 1ns/1ns
module pci_irq_properties
    import pci_irq_pkg::*;
#(
    parameter int NUM_LINES = 2
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [NUM_INTX-1:0] intx_o,
    input wire logic [NUM_INTX-1:0] intx_oe,
    input wire logic [NUM_INTX-1:0] intx_i,
    input wire logic serr_o,
    input wire logic serr_oe,
    input wire logic serr_i,
    input wire logic nmi,
    input wire logic [SEC_LINES-1:0] sec_irq
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_intx_drive_low: assert property (intx_o == '0)
        else $error("request line driven high");
    a_serr_drive_low: assert property (!serr_o)
        else $error("error line driven high");
    a_intx_wire_level: assert property (intx_i == ~intx_oe)
        else $error("request wire level wrong");
    a_serr_wire_level: assert property (serr_i == !serr_oe)
        else $error("error wire level wrong");
    a_upper_lines_idle: assert property ((intx_oe >> NUM_LINES) == '0)
        else $error("unused request line driven");
    a_sec_quiet_idle: assert property ((&intx_i) [*3] |=> (sec_irq == '0))
        else $error("secondary input without request");
    a_sec_follow_line: assert property ($fell(intx_i[0]) |-> ##3 (sec_irq != '0))
        else $error("request not passed on");
    // line level sampled three edges before the output rises: meta, sync, output register
    a_nmi_from_serr: assert property ($rose(nmi) |-> $past(!serr_i, 3))
        else $error("nmi without system error");
    c_nmi_raise: cover property ($rose(nmi));
    c_nmi_drop: cover property ($fell(nmi));
    c_line_b: cover property ($fell(intx_i[1]));
endmodule

// file: sim/tb_top.sv
// self-checking bench: agent and board joined by the interrupt link
`timescale 1ns/1ns
module tb_top;
    import pci_irq_pkg::*;
    logic aclk = 0;
    logic aresetn = 0;
    logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = '0;
    logic [1:0] fn_event = '0, fn_clear = '0, fn_pending;
    logic sys_err = 0, serr_clear = 0, serr_active;
    logic awready, wready, arready, bvalid, rvalid, nmi, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [SEC_LINES-1:0] sec_irq;
    int error_cnt = 0, checked = 0;
    pci_irq_if link ();
    pci_irq_board pci_irq_board_inst (.aclk(aclk), .aresetn(aresetn), .link(link),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .nmi(nmi), .sec_irq(sec_irq),
        .irq(irq));
    pci_irq_agent #(.NUM_FN(2), .NUM_LINES(2), .FN_PIN(16'h0004)) pci_irq_agent_inst (
        .aclk(aclk), .aresetn(aresetn), .link(link), .fn_event(fn_event),
        .fn_clear(fn_clear), .sys_err(sys_err), .serr_clear(serr_clear),
        .fn_pending(fn_pending), .serr_active(serr_active));
    pci_irq_properties #(.NUM_LINES(2)) pci_irq_properties_inst (.aclk(aclk),
        .aresetn(aresetn), .intx_o(link.intx_o), .intx_oe(link.intx_oe),
        .intx_i(link.intx_i), .serr_o(link.serr_o), .serr_oe(link.serr_oe),
        .serr_i(link.serr_i), .nmi(nmi), .sec_irq(sec_irq));
    initial forever #2 aclk = ~aclk;
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge aclk);
        @(negedge aclk);
    endtask
    // one bus transfer; waits bounded, answer taken at the falling edge before the handshake edge
    task automatic xfer(input logic w, input logic [AXI_AW-1:0] a, input logic [31:0] d,
                        input logic [31:0] e, input logic [1:0] er);
        logic ta, tw, tr, done;
        logic [31:0] got;
        logic [1:0] r;
        int n;
        done = 0;
        @(posedge aclk);
        if (w) begin
            awaddr <= a;
            wdata <= d;
            awvalid <= 1;
            wvalid <= 1;
            bready <= 1;
        end else begin
            araddr <= a;
            arvalid <= 1;
            rready <= 1;
        end
        for (n = 0; n < 50 && !done; n++) begin
            @(negedge aclk);
            ta = (awvalid & awready) | (arvalid & arready);
            tw = wvalid & wready;
            tr = (bvalid & bready) | (rvalid & rready);
            r = w ? bresp : rresp;
            got = rdata;
            @(posedge aclk);
            if (ta) awvalid <= 0;
            if (ta) arvalid <= 0;
            if (tw) wvalid <= 0;
            if (tr) bready <= 0;
            if (tr) rready <= 0;
            done = tr;
        end
        if (!done) begin
            error_cnt++;
            $display("[ERR] %0t bus timeout", $time);
            tally_and_finish();
        end else begin
            chk(32'(r), 32'(er), "response code");
            if (!w) chk(got, e, "read data");
        end
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        tick(1);
        chk(32'({nmi, irq, sec_irq}), 32'h0, "outputs after reset");
        xfer(0, ADDR_SSC, 0, 32'h00000000, RESP_OKAY);
        xfer(0, ADDR_ROUTE, 0, 32'h00000688, RESP_OKAY);
        xfer(0, ADDR_NMC, 0, 32'h00000000, RESP_OKAY);
        xfer(0, 12'h300, 0, 32'h00000000, RESP_SLVERR);
        $display("test reset_values done");
        @(posedge aclk);
        fn_event <= 2'h1;
        @(posedge aclk);
        fn_event <= 2'h2;
        @(posedge aclk);
        fn_event <= 2'h0;
        tick(6);
        chk(32'(fn_pending), 32'h3, "pending requests");
        chk(32'(link.intx_i), 32'hC, "line levels");
        chk(32'(sec_irq), 32'h03, "secondary inputs");
        xfer(0, ADDR_EV_STAT, 0, 32'h00000006, RESP_OKAY);
        xfer(1, ADDR_EV_MASK, 32'h00000002, 0, RESP_OKAY);
        tick(2);
        chk(32'(irq), 32'h1, "irq raised");
        xfer(1, ADDR_EV_STAT, 32'h00000006, 0, RESP_OKAY);
        tick(2);
        chk(32'(irq), 32'h0, "irq cleared");
        xfer(1, ADDR_ROUTE, 32'h0000068D, 0, RESP_OKAY);
        tick(2);
        chk(32'(sec_irq), 32'h22, "rerouted inputs");
        @(posedge aclk);
        fn_clear <= 2'h3;
        @(posedge aclk);
        fn_clear <= 2'h0;
        tick(6);
        chk(32'({fn_pending, link.intx_i, sec_irq}), 32'hF00, "requests released");
        $display("test request_lines done");
        @(posedge aclk);
        sys_err <= 1;
        @(posedge aclk);
        sys_err <= 0;
        tick(4);
        chk(32'({serr_active, nmi}), 32'h3, "nmi raised");
        xfer(0, ADDR_SSC, 0, 32'h00000080, RESP_OKAY);
        xfer(1, ADDR_NMC, 32'h00000080, 0, RESP_OKAY);
        tick(1);
        chk(32'(nmi), 32'h0, "nmi masked");
        xfer(1, ADDR_NMC, 32'h00000000, 0, RESP_OKAY);
        @(posedge aclk);
        serr_clear <= 1;
        @(posedge aclk);
        serr_clear <= 0;
        tick(4);
        chk(32'({serr_active, nmi}), 32'h1, "nmi held");
        // reset sequence: enable first, then clear and disable
        xfer(1, ADDR_SSC, 32'h00000000, 0, RESP_OKAY);
        xfer(1, ADDR_SSC, 32'h00000004, 0, RESP_OKAY);
        tick(2);
        chk(32'(nmi), 32'h0, "nmi cleared");
        xfer(0, ADDR_SSC, 0, 32'h00000004, RESP_OKAY);
        @(posedge aclk);
        sys_err <= 1;
        @(posedge aclk);
        sys_err <= 0;
        tick(4);
        chk(32'(nmi), 32'h0, "source disabled");
        xfer(1, ADDR_SSC, 32'h00000000, 0, RESP_OKAY);
        tick(3);
        chk(32'(nmi), 32'h1, "source enabled");
        xfer(0, ADDR_SSC, 0, 32'h00000080, RESP_OKAY);
        $display("test error_nmi done");
        tally_and_finish();
    end
endmodule
